// ### rtl/cir_regs.sv
/*
   Comparator control, two option registers, interrupt mask, flag read-back
   and global interrupt enable of a small microcontroller.
   Assumes the core drives a plain strobe port synchronous to clk, and that
   event sources deliver one-cycle pulses.
*/

// Behaviour
// - Bit 7 enables reference; off frees pin
// - Ratio field bits 6..3, reset all ones
// - Bit 2 shows comparator, read-only
// - Select 00 off, 01 run; pin stays I/O
// - Select 10 drives pin; 11 reserved
// - Pin 5 priority: timer, compare, analog, I/O
// - Pin 3 priority: compare in, analog, I/O
// - Option one bits 7..5 read zero
// - Trim field bits 4..0, reset all ones
// - Option two bits 7..6 read zero
// - Low-voltage-reset level field bits 5..4
// - Oscillator mode bits 3..2, default 11
// - Resolution select bit fixed zero
// - Watchdog period bit 0, default 1
// - Mask register RW, bit 6 zero
// - Mask bit one enables its source
// - Global enable set/cleared by instructions
// - Flag read returns flags AND mask
// - Comparator change sets flag; software clears
module cir_regs (
   input  wire logic        clk,
   input  wire logic        srst,
   input  wire logic [3:0]  reg_addr,
   input  wire logic [7:0]  reg_wdata,
   input  wire logic        reg_wr,
   input  wire logic        reg_rd,
   output logic      [7:0]  reg_rdata,
   input  wire logic        comparator_result,
   input  wire logic [5:0]  event_pulse,
   input  wire logic        enable_interrupts_instr,
   input  wire logic        disable_interrupts_instr,
   input  wire logic        timer_clk_req,
   input  wire logic        analog5_req,
   input  wire logic        analog3_req,
   output logic             internal_ref_on,
   output logic      [3:0]  ref_ratio_field,
   output logic             comparator_enable,
   output logic             inverting_input_gpio,
   output cir_pkg::cir_p55_fn_e port5_pin5_fn,
   output cir_pkg::cir_p53_fn_e port5_pin3_fn,
   output logic      [4:0]  oscillator_trim_field,
   output logic      [1:0]  low_voltage_reset_field,
   output logic      [1:0]  oscillator_mode_field,
   output logic             watchdog_period_select,
   output logic             global_irq_enable,
   output logic             irq_req
);

   // ***************************************************************
   // Storage
   // ***************************************************************
   logic [7:0] cmp_ctrl_r;
   logic [7:0] osc_trim_r;
   logic [7:0] sys_opt_r;
   logic [7:0] irq_mask_r;
   logic [7:0] flag_r;
   logic [7:0] flag_nxt;
   logic       gie_r;
   logic       cmp_prev_r;
   logic [7:0] cmp_view;
   logic [7:0] rdata_nxt;
   logic [7:0] event_vec;
   logic       cmp_change;

   // ***************************************************************
   // Register writes
   // ***************************************************************
   always_ff @(posedge clk) begin
      if (srst) begin
         cmp_ctrl_r <= cir_pkg::CMP_CTRL_RST;
      end else if (reg_wr && reg_addr == cir_pkg::OFS_CMP_CTRL) begin
         cmp_ctrl_r <= reg_wdata & cir_pkg::CMP_CTRL_WMASK;
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         osc_trim_r <= cir_pkg::OSC_TRIM_RST;
      end else if (reg_wr && reg_addr == cir_pkg::OFS_OSC_TRIM) begin
         osc_trim_r <= reg_wdata & cir_pkg::OSC_TRIM_WMASK;
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         sys_opt_r <= cir_pkg::SYS_OPT_RST;
      end else if (reg_wr && reg_addr == cir_pkg::OFS_SYS_OPT) begin
         sys_opt_r <= reg_wdata & cir_pkg::SYS_OPT_WMASK;
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         irq_mask_r <= cir_pkg::IRQ_MASK_RST;
      end else if (reg_wr && reg_addr == cir_pkg::OFS_IRQ_MASK) begin
         irq_mask_r <= reg_wdata & cir_pkg::IRQ_MASK_WMASK;
      end
   end

   // ***************************************************************
   // Global enable
   // ***************************************************************
   always_ff @(posedge clk) begin
      if (srst) begin
         gie_r <= 1'b0;
      end else if (enable_interrupts_instr) begin
         gie_r <= 1'b1;
      end else if (disable_interrupts_instr) begin
         gie_r <= 1'b0;
      end else if (reg_wr && reg_addr == cir_pkg::OFS_GIE_CTRL) begin
         gie_r <= reg_wdata[0];
      end
   end

   // ***************************************************************
   // Event flags
   // ***************************************************************
   // The previous result starts at zero and tracks even while the comparator is off; a high result at reset is not a change.
   always_ff @(posedge clk) begin
      if (srst) begin
         cmp_prev_r <= 1'b0;
      end else begin
         cmp_prev_r <= comparator_result;
      end
   end

   assign cmp_change = comparator_enable && (comparator_result != cmp_prev_r);
   assign event_vec  = {cmp_change, 1'b0, event_pulse};

   // Writing 0 to a flag bit clears it; a new event in the same cycle wins.
   always_comb begin
      flag_nxt = flag_r;
      if (reg_wr && reg_addr == cir_pkg::OFS_IRQ_FLAG) begin
         flag_nxt = flag_r & reg_wdata;
      end
      flag_nxt = (flag_nxt | event_vec) & cir_pkg::IRQ_MASK_WMASK;
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         flag_r <= 8'h00;
      end else begin
         flag_r <= flag_nxt;
      end
   end

   assign irq_req           = gie_r && |(flag_r & irq_mask_r);
   assign global_irq_enable = gie_r;

   // ***************************************************************
   // Control outputs
   // ***************************************************************
   assign internal_ref_on         = cmp_ctrl_r[cir_pkg::CMP_REF_EN_BIT];
   assign inverting_input_gpio    = ~cmp_ctrl_r[cir_pkg::CMP_REF_EN_BIT];
   assign ref_ratio_field         = cmp_ctrl_r[cir_pkg::CMP_RATIO_LSB +: 4];
   assign comparator_enable       = (cmp_ctrl_r[1:0] == cir_pkg::CMP_SEL_RUN) ||
                                    (cmp_ctrl_r[1:0] == cir_pkg::CMP_SEL_PIN);
   assign oscillator_trim_field   = osc_trim_r[cir_pkg::TRIM_LSB +: 5];
   assign low_voltage_reset_field = sys_opt_r[cir_pkg::LVR_LSB +: 2];
   assign oscillator_mode_field   = sys_opt_r[cir_pkg::OSC_MODE_LSB +: 2];
   assign watchdog_period_select  = sys_opt_r[cir_pkg::WDT_SEL_BIT];

   cir_pin_mux u_pin_mux (
      .timer_clk_req (timer_clk_req),
      .cmp_out_req   (cmp_ctrl_r[1:0] == cir_pkg::CMP_SEL_PIN),
      .analog5_req   (analog5_req),
      .cmp_in_req    (comparator_enable),
      .analog3_req   (analog3_req),
      .p55_fn        (port5_pin5_fn),
      .p53_fn        (port5_pin3_fn)
   );

   // ***************************************************************
   // Read port
   // ***************************************************************
   always_comb begin
      cmp_view = cmp_ctrl_r;
      cmp_view[cir_pkg::CMP_RESULT_BIT] = comparator_result;
   end

   always_comb begin
      if (reg_addr == cir_pkg::OFS_CMP_CTRL) begin
         rdata_nxt = cmp_view;
      end else if (reg_addr == cir_pkg::OFS_OSC_TRIM) begin
         rdata_nxt = osc_trim_r;
      end else if (reg_addr == cir_pkg::OFS_SYS_OPT) begin
         rdata_nxt = sys_opt_r;
      end else if (reg_addr == cir_pkg::OFS_IRQ_MASK) begin
         rdata_nxt = irq_mask_r;
      end else if (reg_addr == cir_pkg::OFS_IRQ_FLAG) begin
         rdata_nxt = flag_r & irq_mask_r;
      end else if (reg_addr == cir_pkg::OFS_GIE_CTRL) begin
         rdata_nxt = {7'h00, gie_r};
      end else begin
         rdata_nxt = 8'h00;
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         reg_rdata <= 8'h00;
      end else if (reg_rd) begin
         reg_rdata <= rdata_nxt;
      end else begin
         reg_rdata <= 8'h00;
      end
   end

endmodule : cir_regs

// ### rtl/cir_pkg.sv
/*
   Constants shared by the comparator, option and interrupt mask register bank.
   Assumes an 8-bit register port driven by the core on one clock.
*/
package cir_pkg;

   // ***************************************************************
   // Register offsets
   // ***************************************************************
   localparam logic [3:0] OFS_CMP_CTRL  = 4'h0;
   localparam logic [3:0] OFS_OSC_TRIM  = 4'h1;
   localparam logic [3:0] OFS_SYS_OPT   = 4'h2;
   localparam logic [3:0] OFS_IRQ_MASK  = 4'h3;
   localparam logic [3:0] OFS_IRQ_FLAG  = 4'h4;
   localparam logic [3:0] OFS_GIE_CTRL  = 4'h5;

   // ***************************************************************
   // Field positions
   // ***************************************************************
   localparam int CMP_REF_EN_BIT   = 7;
   localparam int CMP_RATIO_LSB    = 3;
   localparam int CMP_RESULT_BIT   = 2;
   localparam int CMP_SEL_LSB      = 0;
   localparam int TRIM_LSB         = 0;
   localparam int LVR_LSB          = 4;
   localparam int OSC_MODE_LSB     = 2;
   localparam int RES_SEL_BIT      = 1;
   localparam int WDT_SEL_BIT      = 0;
   localparam int FLAG_CMP_BIT     = 7;

   // ***************************************************************
   // Write masks and reset values
   // ***************************************************************
   localparam logic [7:0] CMP_CTRL_WMASK = 8'hFB;
   localparam logic [7:0] OSC_TRIM_WMASK = 8'h1F;
   localparam logic [7:0] SYS_OPT_WMASK  = 8'h3D;
   localparam logic [7:0] IRQ_MASK_WMASK = 8'hBF;
   localparam logic [7:0] CMP_CTRL_RST   = 8'h78;
   localparam logic [7:0] OSC_TRIM_RST   = 8'h1F;
   localparam logic [7:0] SYS_OPT_RST    = 8'h3D;
   localparam logic [7:0] IRQ_MASK_RST   = 8'h00;

   // ***************************************************************
   // Comparator select codes and pin functions
   // ***************************************************************
   localparam logic [1:0] CMP_SEL_OFF  = 2'h0;
   localparam logic [1:0] CMP_SEL_RUN  = 2'h1;
   localparam logic [1:0] CMP_SEL_PIN  = 2'h2;

   typedef enum logic [1:0] {
      P55_GPIO, P55_ANALOG, P55_CMP_OUT, P55_TIMER_CLK
   } cir_p55_fn_e;

   typedef enum logic [1:0] {
      P53_GPIO, P53_ANALOG, P53_CMP_IN
   } cir_p53_fn_e;

endpackage : cir_pkg

// ### rtl/cir_pin_mux.sv
/*
   Priority selection of the functions of port 5 pins 5 and 3.
   Assumes function requests are synchronous levels.
*/
module cir_pin_mux (
   input  wire logic                 timer_clk_req,
   input  wire logic                 cmp_out_req,
   input  wire logic                 analog5_req,
   input  wire logic                 cmp_in_req,
   input  wire logic                 analog3_req,
   output cir_pkg::cir_p55_fn_e      p55_fn,
   output cir_pkg::cir_p53_fn_e      p53_fn
);

   always_comb begin
      if (timer_clk_req) begin
         p55_fn = cir_pkg::P55_TIMER_CLK;
      end else if (cmp_out_req) begin
         p55_fn = cir_pkg::P55_CMP_OUT;
      end else if (analog5_req) begin
         p55_fn = cir_pkg::P55_ANALOG;
      end else begin
         p55_fn = cir_pkg::P55_GPIO;
      end
   end

   always_comb begin
      if (cmp_in_req) begin
         p53_fn = cir_pkg::P53_CMP_IN;
      end else if (analog3_req) begin
         p53_fn = cir_pkg::P53_ANALOG;
      end else begin
         p53_fn = cir_pkg::P53_GPIO;
      end
   end

endmodule : cir_pin_mux

// ### testbench/cir_regs_props.sv
/*
   Checker of the register bank port behaviour.
   Assumes it is bound to cir_regs and sees only its ports.
*/
module cir_regs_props (
   input  wire logic           clk,
   input  wire logic           srst,
   input  wire logic [3:0]     reg_addr,
   input  wire logic [7:0]     reg_wdata,
   input  wire logic           reg_wr,
   input  wire logic           reg_rd,
   input  wire logic [7:0]     reg_rdata,
   input  wire logic           comparator_result,
   input  wire logic           enable_interrupts_instr,
   input  wire logic           timer_clk_req,
   input  wire logic           internal_ref_on,
   input  wire logic [3:0]     ref_ratio_field,
   input  wire logic           comparator_enable,
   input  cir_pkg::cir_p55_fn_e port5_pin5_fn,
   input  cir_pkg::cir_p53_fn_e port5_pin3_fn,
   input  wire logic           global_irq_enable,
   input  wire logic           irq_req
);
   timeunit 1ns;
   timeprecision 1ps;
   // ***************************************************************
   // Properties
   // ***************************************************************
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (srst);
   sequence s_ctrl_wr;
      reg_wr && reg_addr == cir_pkg::OFS_CMP_CTRL;
   endsequence
   // The bench leaves one idle cycle between a write and the read that follows it.
   sequence s_mask_wr_rd;
      reg_wr && reg_addr == cir_pkg::OFS_IRQ_MASK ##1 !reg_wr
         ##1 reg_rd && reg_addr == cir_pkg::OFS_IRQ_MASK;
   endsequence
   property p_ctrl_wr;
      s_ctrl_wr |=> ref_ratio_field == $past(reg_wdata[6:3]) && internal_ref_on == $past(reg_wdata[7]);
   endproperty
   a_ctrl_wr: assert property (p_ctrl_wr) else $error("control fields not loaded");
   property p_sel;
      s_ctrl_wr |=> comparator_enable == ($past(reg_wdata[1:0]) inside {2'h1, 2'h2});
   endproperty
   a_sel: assert property (p_sel) else $error("comparator enable wrong");
   property p_cmp_rd;
      reg_rd && reg_addr == cir_pkg::OFS_CMP_CTRL |=> reg_rdata[2] == $past(comparator_result);
   endproperty
   a_cmp_rd: assert property (p_cmp_rd) else $error("result bit wrong");
   property p_pin5;
      timer_clk_req |-> port5_pin5_fn == cir_pkg::P55_TIMER_CLK;
   endproperty
   a_pin5: assert property (p_pin5) else $error("timer clock lost pin 5");
   property p_pin3;
      comparator_enable |-> port5_pin3_fn == cir_pkg::P53_CMP_IN;
   endproperty
   a_pin3: assert property (p_pin3) else $error("pin 3 not comparator input");
   property p_mask_rd;
      s_mask_wr_rd |=> reg_rdata == ($past(reg_wdata, 3) & cir_pkg::IRQ_MASK_WMASK);
   endproperty
   a_mask_rd: assert property (p_mask_rd) else $error("mask readback wrong");
   property p_gie_on;
      enable_interrupts_instr |=> global_irq_enable;
   endproperty
   a_gie_on: assert property (p_gie_on) else $error("global enable not set");
   property p_irq;
      !global_irq_enable |-> !irq_req;
   endproperty
   a_irq: assert property (p_irq) else $error("request without global enable");
endmodule : cir_regs_props

bind cir_regs cir_regs_props u_props (.clk, .srst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
   .reg_rdata, .comparator_result, .enable_interrupts_instr, .timer_clk_req, .internal_ref_on,
   .ref_ratio_field, .comparator_enable, .port5_pin5_fn, .port5_pin3_fn, .global_irq_enable,
   .irq_req);

// ### testbench/cir_regs_tb.sv
/*
   Self-checking bench of the register bank.
   Assumes the package, the design and the checker are compiled before it.
*/
module cir_regs_tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk, srst, reg_wr, reg_rd, comparator_result, enable_interrupts_instr;
   logic disable_interrupts_instr, timer_clk_req, analog5_req, analog3_req, irq_req;
   logic internal_ref_on, comparator_enable, inverting_input_gpio, watchdog_period_select;
   logic global_irq_enable;
   logic [3:0] reg_addr, ref_ratio_field;
   logic [7:0] reg_wdata, reg_rdata, q[$], sh[4], wm[4];
   logic [5:0] event_pulse;
   logic [4:0] oscillator_trim_field;
   logic [1:0] low_voltage_reset_field, oscillator_mode_field;
   cir_pkg::cir_p55_fn_e port5_pin5_fn;
   cir_pkg::cir_p53_fn_e port5_pin3_fn;
   int miscompares, check_count, cyc;
   logic [31:0] seed = 32'h3E50CD1B;

   cir_regs uut (.clk, .srst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
      .comparator_result, .event_pulse, .enable_interrupts_instr, .disable_interrupts_instr,
      .timer_clk_req, .analog5_req, .analog3_req, .internal_ref_on, .ref_ratio_field,
      .comparator_enable, .inverting_input_gpio, .port5_pin5_fn, .port5_pin3_fn,
      .oscillator_trim_field, .low_voltage_reset_field, .oscillator_mode_field,
      .watchdog_period_select, .global_irq_enable, .irq_req);

   // ***************************************************************
   // Bus tasks and comparison
   // ***************************************************************
   function automatic logic [31:0] xs();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction : xs
   task automatic chk(string n, logic [7:0] e, logic [7:0] g);
      check_count++;
      if (g !== e) begin
         miscompares++;
         $display("[ERR] %s expected %h seen %h", n, e, g);
      end
   endtask : chk
   task automatic wr(logic [3:0] a, logic [7:0] d);
      @(posedge clk);
      reg_wr <= 1'b1; reg_addr <= a; reg_wdata <= d;
      @(posedge clk);
      reg_wr <= 1'b0;
   endtask : wr
   task automatic rd(logic [3:0] a, logic [7:0] e);
      @(posedge clk);
      reg_rd <= 1'b1; reg_addr <= a; q.push_back(e);
      @(posedge clk);
      reg_rd <= 1'b0;
   endtask : rd
   task automatic pulse(logic [7:0] v);
      @(posedge clk);
      {enable_interrupts_instr, disable_interrupts_instr, event_pulse} <= v;
      @(posedge clk);
      {enable_interrupts_instr, disable_interrupts_instr, event_pulse} <= 8'h00;
   endtask : pulse
   task automatic outs();
      #1 chk("ctrl", sh[0] & 8'hF8, {internal_ref_on, ref_ratio_field, 3'h0});
      chk("trim", sh[1], {3'h0, oscillator_trim_field});
      chk("opt", sh[2] & 8'h3D, {2'h0, low_voltage_reset_field, oscillator_mode_field, 1'b0,
         watchdog_period_select});
      chk("gpio", {7'h0, ~sh[0][7]}, {7'h0, inverting_input_gpio});
      chk("cmp_en", {7'h0, sh[0][1:0] == 2'h1 || sh[0][1:0] == 2'h2},
         {7'h0, comparator_enable});
   endtask : outs
   task automatic give_verdict();
      $display("checks %0d mismatches %0d", check_count, miscompares);
      if (miscompares == 0 && check_count > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask : give_verdict

   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end
   always @(posedge clk) begin
      cyc++;
      if (cyc == 3000) begin
         miscompares++;
         give_verdict();
      end
   end
   initial begin
      bit pend;
      pend = 1'b0;
      forever begin
         @(posedge clk);
         if (pend) chk("reg_rdata", q.pop_front(), reg_rdata);
         pend = reg_rd;
      end
   end

   initial begin
      int a;
      logic [7:0] d, m, ev;
      {srst, reg_wr, reg_rd, comparator_result, enable_interrupts_instr} = 5'h10;
      {disable_interrupts_instr, timer_clk_req, analog5_req, analog3_req} = 4'h0;
      reg_addr = 4'h0; reg_wdata = 8'h00; event_pulse = 6'h00;
      wm = '{cir_pkg::CMP_CTRL_WMASK, 8'h1F, 8'h3D, 8'hBF};
      sh = '{8'h78, 8'h1F, 8'h3D, 8'h00};
      repeat (5) @(posedge clk);
      srst <= 1'b0;
      for (int i = 0; i < 4; i++) rd(i[3:0], sh[i]);
      outs();
      rd(4'hC, 8'h00);
      $display("reset values done");
      for (int i = 0; i < 12; i++) begin
         a = i % 4; d = 8'(xs());
         comparator_result <= d[7];
         wr(a[3:0], d);
         sh[a] = d & wm[a];
         rd(a[3:0], sh[a] | (a == 0 ? {5'h0, d[7], 2'h0} : 8'h00));
         outs();
      end
      wr(4'hC, 8'(xs()));
      rd(4'hC, 8'h00);
      $display("register access done");
      for (int s = 0; s < 32; s++) begin
         if (s % 8 == 0) wr(4'h0, {6'h0, s[4:3]});
         @(posedge clk);
         {timer_clk_req, analog5_req, analog3_req} <= s[2:0];
         #1 chk("pin5", s[2] ? cir_pkg::P55_TIMER_CLK : s[4:3] == 2'h2 ? cir_pkg::P55_CMP_OUT
            : s[1] ? cir_pkg::P55_ANALOG : cir_pkg::P55_GPIO, {6'h0, port5_pin5_fn});
         chk("pin3", (s[4:3] == 2'h1 || s[4:3] == 2'h2) ? cir_pkg::P53_CMP_IN
            : s[0] ? cir_pkg::P53_ANALOG : cir_pkg::P53_GPIO, {6'h0, port5_pin3_fn});
      end
      {timer_clk_req, analog5_req, analog3_req} <= 3'h0;
      $display("pin priority done");
      wr(4'h0, 8'h01);
      for (int i = 0; i < 4; i++) begin
         m = 8'(xs()) & 8'hBF; ev = 8'(xs()) & 8'h3F;
         wr(4'h4, 8'h00);
         wr(4'h3, m);
         pulse(ev);
         comparator_result <= ~comparator_result;
         repeat (2) @(posedge clk);
         d = (ev | 8'h80) & m;
         rd(4'h4, d);
         #1 chk("irq", 8'h00, {7'h0, irq_req});
         pulse(8'h80);
         #1 chk("irq", {7'h0, |d}, {7'h0, irq_req});
         rd(4'h5, 8'h01);
         pulse(8'h40);
         #1 chk("irq", 8'h00, {7'h0, irq_req});
         rd(4'h5, 8'h00);
      end
      wr(4'h5, 8'h01);
      rd(4'h5, 8'h01);
      wr(4'h5, 8'h00);
      rd(4'h5, 8'h00);
      $display("interrupt mask done");
      give_verdict();
   end
endmodule : cir_regs_tb
